// ### psw_pkg.sv
// Package for the power-save, watchdog and wake controller.
// Assumes a single 40 MHz clock domain; shared by all design files.
package psw_pkg;

  // ****************************************************************
  // Configuration word map
  // ****************************************************************
  localparam logic [23:0] PSW_ADDR_OSC_SEL = 24'hf80006;
  localparam logic [23:0] PSW_ADDR_OSC_CFG = 24'hf80008;
  localparam logic [23:0] PSW_ADDR_WDT_CFG = 24'hf8000a;
  localparam logic [23:0] PSW_ADDR_POR_CFG = 24'hf8000c;
  localparam int          PSW_CFG_USED_W   = 16;
  localparam int          PSW_WDT_EN_BIT   = 7;
  localparam logic [15:0] PSW_ERASED_WORD  = 16'hffff;

  // ****************************************************************
  // Status register layout
  // ****************************************************************
  localparam int PSW_RESET_CONTROL_STATUS_REG_SLEEP = 3;
  localparam int PSW_RESET_CONTROL_STATUS_REG_IDLE  = 2;
  localparam int PSW_RESET_CONTROL_STATUS_REG_SWDT  = 5;
  localparam int PSW_RESET_CONTROL_STATUS_REG_WATCHDOG_TIMEOUT_FLAG  = 4;

  // ****************************************************************
  // Operands and oscillator selections
  // ****************************************************************
  localparam logic       PSW_OP_SLEEP = 1'h0;
  localparam logic       PSW_OP_IDLE  = 1'h1;
  localparam logic [2:0] PSW_OSC_FRC  = 3'h0;
  localparam logic [2:0] PSW_OSC_PRI  = 3'h2;
  localparam logic [2:0] PSW_OSC_PLL  = 3'h3;
  localparam logic [2:0] PSW_OSC_LP   = 3'h4;
  localparam logic [2:0] PSW_OSC_EC   = 3'h7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int PSW_CLK_MHZ       = 40;
  localparam int PSW_SETTLE_US     = 10;
  localparam int PSW_SETTLE_CYC    = PSW_SETTLE_US * PSW_CLK_MHZ;
  localparam int PSW_CNT_W         = 24;
  localparam int PSW_WDT_W         = 16;
  localparam logic [PSW_WDT_W-1:0] PSW_WDT_START = 16'h0000;

  typedef enum logic [2:0] {
    PSW_RUN    = 3'b000,
    PSW_IDLE   = 3'b001,
    PSW_SLEEP  = 3'b011,
    PSW_SETTLE = 3'b010,
    PSW_OSCW   = 3'b110,
    PSW_POWERUP_TIMER   = 3'b111
  } psw_state_t;

endpackage : psw_pkg

// ### psw_wdt_if.sv
// Interface carrying watchdog control and status between modules.
// Assumes both ends share mclk.
`timescale 1ns/100ps
interface psw_wdt_if;
  logic run;
  logic clear;
  logic timeout;
  modport ctrl (output run, output clear, input timeout);
  modport cnt  (input run, input clear, output timeout);
endinterface : psw_wdt_if

// ### psw_wdt_cnt.sv
// Watchdog up-counter ticking on low-power RC ticks.
// Assumes low_power_rc_osc_tick is a one-cycle pulse synchronous to mclk.
`timescale 1ns/100ps
module psw_wdt_cnt
  import psw_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic low_power_rc_osc_tick,
  psw_wdt_if.cnt    wdt
);
  logic [PSW_WDT_W-1:0] cnt_q;
  logic                 to_q;

  // The count advances only on RC ticks, so it runs with the main clock failed.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= PSW_WDT_START;
    end else if (wdt.clear || !wdt.run) begin
      cnt_q <= PSW_WDT_START;
    end else if (low_power_rc_osc_tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      to_q <= 1'b0;
    end else begin
      to_q <= wdt.run && !wdt.clear && low_power_rc_osc_tick && (&cnt_q);
    end
  end

  assign wdt.timeout = to_q;
endmodule : psw_wdt_cnt

// ### psw_dly_cnt.sv
// Down counter for wake delays.
// Assumes load is a one-cycle pulse; done is high while idle at zero.
`timescale 1ns/100ps
module psw_dly_cnt
  import psw_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 load,
  input  wire logic [PSW_CNT_W-1:0] value,
  output logic                      done
);
  logic [PSW_CNT_W-1:0] cnt_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign done = (cnt_q == '0) && !load;
endmodule : psw_dly_cnt

// ### psw_ctrl.sv
// Power-save, watchdog and wake sequencer with config and status registers.
// Assumes core, interrupt logic, oscillator and reset sources are synchronous to mclk.
`timescale 1ns/100ps

// Notes on behaviour
// - Watchdog enable via config bit or software bit.
// - Config bit one forces watchdog on; erased one.
// - Overflow resets device except during Sleep; code also skips the reset in Idle.
// - Config bit zero: software bit five enables.
// - Power-save instruction enters Sleep or Idle.
// - Sleep gates CPU, peripherals, on-chip oscillator.
// - No clock monitor in Sleep; RC kept.
// - Sleep ends on interrupt, reset or time-out.
// - Wake restarts previously active clock source.
// - Crystal waits start-up timer; PLL waits lock.
// - External or fast RC: settle delay only.
// - Running low-power crystal: settle delay only.
// - Interrupt wake from Sleep sets sleep flag.
// - Clock dead: trap to fast RC, else wait.
// - Non power-on reset sets sleep; power-on clears.
// - Time-out in Sleep wakes, sets sleep, time-out.
// - Idle gates CPU only; peripherals may stop.
// - Idle wakes at once, no delay.
// - Idle wake sets idle flag; power-on clears.
// - Time-out in Idle sets idle and time-out.
// - Config words 24 bits, lower 16 used, read-only.
// - Watchdog counts on its own RC clock.
module psw_ctrl
  import psw_pkg::*;
#(
  parameter int POWERUP_TIMER_CYC = 160000,
  parameter int OST_CYC  = 40960,
  parameter int LOCK_CYC = 8000
)(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        por_evt,
  input  wire logic        master_clear_pin_evt,
  input  wire logic [15:0] cfg_osc_sel,
  input  wire logic [15:0] cfg_osc,
  input  wire logic [15:0] cfg_wdt,
  input  wire logic [15:0] cfg_por,
  input  wire logic        tbl_rd,
  input  wire logic [23:0] tbl_addr,
  input  wire logic        reset_control_status_reg_wr,
  input  wire logic [15:0] reset_control_status_reg_wdata,
  input  wire logic        pwrsave_exec,
  input  wire logic        pwrsave_op,
  input  wire logic        watchdog_clear_instruction_exec,
  input  wire logic        irq_wake,
  input  wire logic        low_power_rc_osc_tick,
  input  wire logic [2:0]  cur_osc_sel,
  input  wire logic        clk_switch_en,
  input  wire logic        pll_locked,
  input  wire logic        osc_running,
  input  wire logic        fail_safe_clock_monitor_en,
  input  wire logic [7:0]  periph_idle_stop,
  output logic [23:0]      tbl_rdata,
  output logic [15:0]      reset_control_status_reg_rdata,
  output logic             cpu_clk_en,
  output logic [7:0]       periph_clk_en,
  output logic             osc_en,
  output logic [2:0]       osc_restart_sel,
  output logic             low_power_rc_osc_en,
  output logic             fail_safe_clock_monitor_active,
  output logic             sys_reset,
  output logic             clk_fail_trap,
  output logic             resume_pulse
);

  // ****************************************************************
  // Watchdog enable and counter
  // ****************************************************************
  psw_wdt_if  wdt ();
  psw_state_t st_q;
  logic       swdt_q;
  logic       hw_en;
  logic       in_sleep;
  logic       in_idle;
  logic       rst_evt;

  assign hw_en    = cfg_wdt[PSW_WDT_EN_BIT];
  assign wdt.run  = hw_en || swdt_q;
  assign wdt.clear = watchdog_clear_instruction_exec;
  assign in_sleep = (st_q == PSW_SLEEP);
  assign in_idle  = (st_q == PSW_IDLE);
  assign rst_evt  = por_evt || master_clear_pin_evt;

  psw_wdt_cnt u_wdt (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .low_power_rc_osc_tick (low_power_rc_osc_tick),
    .wdt       (wdt)
  );

  // ****************************************************************
  // Wake delay selection
  // ****************************************************************
  logic                 dly_load;
  logic [PSW_CNT_W-1:0] dly_val;
  logic                 dly_done;
  logic [2:0]           wake_src;
  logic                 lp_kept_q;

  function automatic logic is_crystal(input logic [2:0] s);
    is_crystal = (s == PSW_OSC_PRI) || (s == PSW_OSC_PLL);
  endfunction : is_crystal

  // A PLL source only counts as usable once it reports lock as well as running.
  function automatic logic clk_ready(input logic [2:0] s, input logic run, input logic lock);
    clk_ready = run && (s != PSW_OSC_PLL || lock);
  endfunction : clk_ready

  assign wake_src = clk_switch_en ? cur_osc_sel : cfg_osc[2:0];

  psw_dly_cnt u_dly (
    .mclk  (mclk),
    .rst_n (rst_n),
    .load  (dly_load),
    .value (dly_val),
    .done  (dly_done)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  logic wake_evt;
  assign wake_evt = irq_wake || rst_evt || wdt.timeout;
  logic save_go;
  assign save_go  = (st_q == PSW_RUN) && pwrsave_exec && !rst_evt;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= PSW_RUN;
      dly_load  <= 1'b0;
      dly_val   <= '0;
      lp_kept_q <= 1'b0;
    end else begin
      dly_load <= 1'b0;
      unique case (st_q)
        PSW_RUN: begin
          if (save_go) begin
            st_q      <= (pwrsave_op == PSW_OP_IDLE) ? PSW_IDLE : PSW_SLEEP;
            lp_kept_q <= (wake_src == PSW_OSC_LP);
          end
        end
        PSW_IDLE: begin
          if (wake_evt) begin
            st_q <= PSW_RUN;
          end
        end
        PSW_SLEEP: begin
          if (wake_evt) begin
            st_q     <= PSW_SETTLE;
            dly_load <= 1'b1;
            dly_val  <= PSW_CNT_W'(PSW_SETTLE_CYC);
          end
        end
        PSW_SETTLE: begin
          if (dly_done && !dly_load) begin
            if (is_crystal(wake_src) && !(lp_kept_q && wake_src == PSW_OSC_LP)) begin
              st_q     <= PSW_OSCW;
              dly_load <= 1'b1;
              dly_val  <= PSW_CNT_W'(wake_src == PSW_OSC_PLL ? OST_CYC + LOCK_CYC : OST_CYC);
            end else begin
              st_q <= PSW_RUN;
            end
          end
        end
        PSW_OSCW: begin
          if (dly_done && !dly_load) begin
            st_q     <= PSW_POWERUP_TIMER;
            dly_load <= 1'b1;
            dly_val  <= (cfg_por[2:0] == 3'h0) ? '0 : PSW_CNT_W'(POWERUP_TIMER_CYC);
          end
        end
        PSW_POWERUP_TIMER: begin
          if (dly_done && !dly_load) begin
            if (clk_ready(wake_src, osc_running, pll_locked)) begin
              st_q <= PSW_RUN;
            end else if (fail_safe_clock_monitor_en) begin
              st_q <= PSW_RUN;
            end
          end
        end
        default: begin
          st_q <= PSW_RUN;
        end
      endcase
    end
  end

  // ****************************************************************
  // Clock failure trap
  // ****************************************************************
  logic trap_now;
  logic frc_hold_q;

  // The trap fires when the power-up timer of a crystal or PLL wake is spent, the clock monitor is enabled and the clock is still dead.
  assign trap_now = (st_q == PSW_POWERUP_TIMER) && dly_done && !dly_load && fail_safe_clock_monitor_en &&
                    !clk_ready(wake_src, osc_running, pll_locked);

  // The fast RC stays selected after a trap until software next enters Sleep or Idle, so a
  // failed crystal is never restarted behind the back of the trap handler.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      frc_hold_q <= 1'b0;
    end else if (trap_now) begin
      frc_hold_q <= 1'b1;
    end else if (save_go) begin
      frc_hold_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Status register
  // ****************************************************************
  logic sleep_f_q;
  logic idle_f_q;
  logic watchdog_timeout_flag_f_q;

  // Hardware set wins over a software write in the same cycle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_f_q <= 1'b0;
      idle_f_q  <= 1'b0;
      watchdog_timeout_flag_f_q  <= 1'b0;
      swdt_q    <= 1'b0;
    end else begin
      if (reset_control_status_reg_wr) begin
        sleep_f_q <= reset_control_status_reg_wdata[PSW_RESET_CONTROL_STATUS_REG_SLEEP];
        idle_f_q  <= reset_control_status_reg_wdata[PSW_RESET_CONTROL_STATUS_REG_IDLE];
        watchdog_timeout_flag_f_q  <= reset_control_status_reg_wdata[PSW_RESET_CONTROL_STATUS_REG_WATCHDOG_TIMEOUT_FLAG];
        swdt_q    <= reset_control_status_reg_wdata[PSW_RESET_CONTROL_STATUS_REG_SWDT];
      end
      if (in_sleep && (irq_wake || master_clear_pin_evt || wdt.timeout)) begin
        sleep_f_q <= 1'b1;
      end
      if (in_idle && (irq_wake || master_clear_pin_evt || wdt.timeout)) begin
        idle_f_q <= 1'b1;
      end
      if (wdt.timeout && wdt.run) begin
        watchdog_timeout_flag_f_q <= 1'b1;
      end
      if (por_evt) begin
        sleep_f_q <= 1'b0;
        idle_f_q  <= 1'b0;
        watchdog_timeout_flag_f_q  <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tbl_rdata  <= '0;
      reset_control_status_reg_rdata <= '0;
    end else begin
      unique case (tbl_addr)
        PSW_ADDR_OSC_SEL: tbl_rdata <= {8'h00, cfg_osc_sel};
        PSW_ADDR_OSC_CFG: tbl_rdata <= {8'h00, cfg_osc};
        PSW_ADDR_WDT_CFG: tbl_rdata <= {8'h00, cfg_wdt};
        PSW_ADDR_POR_CFG: tbl_rdata <= {8'h00, cfg_por};
        default:          tbl_rdata <= '0;
      endcase
      if (!tbl_rd) begin
        tbl_rdata <= '0;
      end
      reset_control_status_reg_rdata <= '0;
      reset_control_status_reg_rdata[PSW_RESET_CONTROL_STATUS_REG_SLEEP] <= sleep_f_q;
      reset_control_status_reg_rdata[PSW_RESET_CONTROL_STATUS_REG_IDLE]  <= idle_f_q;
      reset_control_status_reg_rdata[PSW_RESET_CONTROL_STATUS_REG_WATCHDOG_TIMEOUT_FLAG]  <= watchdog_timeout_flag_f_q;
      reset_control_status_reg_rdata[PSW_RESET_CONTROL_STATUS_REG_SWDT]  <= swdt_q;
    end
  end

  logic sleepish;
  assign sleepish = in_sleep || st_q == PSW_SETTLE || st_q == PSW_OSCW || st_q == PSW_POWERUP_TIMER;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en      <= 1'b1;
      periph_clk_en   <= '1;
      osc_en          <= 1'b1;
      osc_restart_sel <= PSW_OSC_FRC;
      low_power_rc_osc_en         <= 1'b1;
      fail_safe_clock_monitor_active     <= 1'b0;
      sys_reset       <= 1'b0;
      clk_fail_trap   <= 1'b0;
      resume_pulse    <= 1'b0;
    end else begin
      cpu_clk_en      <= (st_q == PSW_RUN);
      periph_clk_en   <= sleepish ? '0 : (in_idle ? ~periph_idle_stop : '1);
      osc_en          <= !in_sleep || (lp_kept_q && wake_src == PSW_OSC_LP);
      osc_restart_sel <= (trap_now || frc_hold_q) ? PSW_OSC_FRC : wake_src;
      low_power_rc_osc_en         <= wdt.run || (fail_safe_clock_monitor_en && !sleepish);
      fail_safe_clock_monitor_active     <= fail_safe_clock_monitor_en && !sleepish;
      sys_reset       <= wdt.timeout && !in_sleep && !in_idle;
      clk_fail_trap   <= trap_now;
      resume_pulse    <= in_idle && wake_evt;
    end
  end

endmodule : psw_ctrl

// ### psw_ctrl_checker.sv
// Checker of the power-save controller, watching its ports only.
// Assumes one clock, mclk, and reset rst_n; bound to psw_ctrl below.
`timescale 1ns/100ps
module psw_ctrl_checker
  import psw_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        por_evt,
  input wire logic        master_clear_pin_evt,
  input wire logic        irq_wake,
  input wire logic        pwrsave_exec,
  input wire logic        pwrsave_op,
  input wire logic        fail_safe_clock_monitor_en,
  input wire logic        tbl_rd,
  input wire logic [23:0] tbl_addr,
  input wire logic [15:0] cfg_wdt,
  input wire logic [7:0]  periph_idle_stop,
  input wire logic [23:0] tbl_rdata,
  input wire logic        cpu_clk_en,
  input wire logic [7:0]  periph_clk_en,
  input wire logic        osc_en,
  input wire logic        low_power_rc_osc_en,
  input wire logic        fail_safe_clock_monitor_active,
  input wire logic        sys_reset,
  input wire logic        clk_fail_trap,
  input wire logic        resume_pulse
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // The ports do not show the state, so a running CPU clock stands in for it.
  logic go;
  logic asleep;
  assign go     = pwrsave_exec && cpu_clk_en && !por_evt && !master_clear_pin_evt && !irq_wake;
  assign asleep = !cpu_clk_en && !osc_en;
  sleep_gate_a: assert property (go && pwrsave_op == PSW_OP_SLEEP |-> ##2 !cpu_clk_en && periph_clk_en == 8'h00)
    else $error("sleep entry left a clock running");
  idle_gate_a: assert property (go && pwrsave_op == PSW_OP_IDLE |-> ##2 !cpu_clk_en && periph_clk_en == ~periph_idle_stop)
    else $error("idle entry gated the wrong clocks");
  idle_wake_a: assert property (resume_pulse |-> ##[0:1] cpu_clk_en)
    else $error("cpu clock late after idle wake");
  wdt_low_power_rc_osc_a: assert property (cfg_wdt[PSW_WDT_EN_BIT] |=> low_power_rc_osc_en)
    else $error("watchdog clock off while forced on");
  cfg_read_a: assert property (tbl_rd && tbl_addr == PSW_ADDR_WDT_CFG |=> tbl_rdata == {8'h00, $past(cfg_wdt)})
    else $error("watchdog word read wrong");
  sleep_fail_safe_clock_monitor_a: assert property (asleep |-> !fail_safe_clock_monitor_active)
    else $error("clock monitor active in sleep");
  sleep_reset_a: assert property (asleep |-> !sys_reset)
    else $error("reset raised during sleep");
  trap_fail_safe_clock_monitor_a: assert property (clk_fail_trap |-> fail_safe_clock_monitor_en)
    else $error("trap without clock monitor");
  cover property (go && pwrsave_op == PSW_OP_SLEEP);
  cover property (resume_pulse);
  cover property (clk_fail_trap);
endmodule : psw_ctrl_checker
bind psw_ctrl psw_ctrl_checker chk (
  .mclk(mclk), .rst_n(rst_n), .por_evt(por_evt), .master_clear_pin_evt(master_clear_pin_evt), .irq_wake(irq_wake),
  .pwrsave_exec(pwrsave_exec), .pwrsave_op(pwrsave_op), .fail_safe_clock_monitor_en(fail_safe_clock_monitor_en), .tbl_rd(tbl_rd),
  .tbl_addr(tbl_addr), .cfg_wdt(cfg_wdt), .periph_idle_stop(periph_idle_stop), .tbl_rdata(tbl_rdata),
  .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_en(osc_en), .low_power_rc_osc_en(low_power_rc_osc_en),
  .fail_safe_clock_monitor_active(fail_safe_clock_monitor_active), .sys_reset(sys_reset), .clk_fail_trap(clk_fail_trap),
  .resume_pulse(resume_pulse));

// ### psw_osc_model.sv
// Behavioural oscillator and PLL at the far side of the controller.
// Assumes osc_en from the controller; dead holds the crystal stopped.
`timescale 1ns/100ps
module psw_osc_model (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic osc_en,
  input  wire logic dead,
  output logic      osc_running,
  output logic      pll_locked
);
  // ****************************************************************
  // Start-up model
  // ****************************************************************
  // A crystal takes time to start, so wake delays are not met for free.
  logic [5:0] age_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      age_q <= 6'h3f;
    end else if (!osc_en || dead) begin
      age_q <= 6'h00;
    end else if (age_q != 6'h3f) begin
      age_q <= age_q + 6'h01;
    end
  end
  assign osc_running = age_q >= 6'h14;
  assign pll_locked  = age_q >= 6'h1e;
endmodule : psw_osc_model

// ### tb.sv
// Testbench of the power-save, watchdog and wake controller.
// Assumes the oscillator model as far side; short start-up parameters.
`timescale 1ns/100ps
module tb;
  import psw_pkg::*;
  logic        mclk, rst_n, por_evt, master_clear_pin_evt, tbl_rd, reset_control_status_reg_wr, pwrsave_exec, pwrsave_op;
  logic        watchdog_clear_instruction_exec, irq_wake, low_power_rc_osc_tick, clk_switch_en, pll_locked, osc_running, fail_safe_clock_monitor_en, dead;
  logic [15:0] cfg_osc_sel, cfg_osc, cfg_wdt, cfg_por, reset_control_status_reg_wdata, reset_control_status_reg_rdata;
  logic [23:0] tbl_addr, tbl_rdata;
  logic [2:0]  cur_osc_sel, osc_restart_sel;
  logic [7:0]  periph_idle_stop, periph_clk_en;
  logic        cpu_clk_en, osc_en, low_power_rc_osc_en, fail_safe_clock_monitor_active, sys_reset, clk_fail_trap, resume_pulse;
  int          mismatches, n_tests, cyc;
  logic [5:0]  pls;
  logic        rst_seen;
  localparam int P_SAVE = 0, P_WR = 1, P_IRQ = 2, P_CLR = 3, P_MASTER_CLEAR_PIN = 4, P_POR = 5;
  // One-cycle strobes share a vector so that a single task can pulse any of them.
  assign {por_evt, master_clear_pin_evt, watchdog_clear_instruction_exec, irq_wake, reset_control_status_reg_wr, pwrsave_exec} = pls;
  psw_ctrl #(.POWERUP_TIMER_CYC(8), .OST_CYC(8), .LOCK_CYC(8)) DUT (
    .mclk(mclk), .rst_n(rst_n), .por_evt(por_evt), .master_clear_pin_evt(master_clear_pin_evt), .cfg_osc_sel(cfg_osc_sel),
    .cfg_osc(cfg_osc), .cfg_wdt(cfg_wdt), .cfg_por(cfg_por), .tbl_rd(tbl_rd), .tbl_addr(tbl_addr),
    .reset_control_status_reg_wr(reset_control_status_reg_wr), .reset_control_status_reg_wdata(reset_control_status_reg_wdata), .pwrsave_exec(pwrsave_exec), .pwrsave_op(pwrsave_op),
    .watchdog_clear_instruction_exec(watchdog_clear_instruction_exec), .irq_wake(irq_wake), .low_power_rc_osc_tick(low_power_rc_osc_tick), .cur_osc_sel(cur_osc_sel),
    .clk_switch_en(clk_switch_en), .pll_locked(pll_locked), .osc_running(osc_running), .fail_safe_clock_monitor_en(fail_safe_clock_monitor_en),
    .periph_idle_stop(periph_idle_stop), .tbl_rdata(tbl_rdata), .reset_control_status_reg_rdata(reset_control_status_reg_rdata),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_en(osc_en),
    .osc_restart_sel(osc_restart_sel), .low_power_rc_osc_en(low_power_rc_osc_en), .fail_safe_clock_monitor_active(fail_safe_clock_monitor_active),
    .sys_reset(sys_reset), .clk_fail_trap(clk_fail_trap), .resume_pulse(resume_pulse));
  psw_osc_model partner (.mclk(mclk), .rst_n(rst_n), .osc_en(osc_en), .dead(dead),
                         .osc_running(osc_running), .pll_locked(pll_locked));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  // The ceiling sits well above the longest run, the watchdog overflow.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      mismatches++;
      $display("CHECK FAILED at %0t: cycle limit reached", $time);
      end_of_test();
    end
  end
  always @(posedge mclk) begin
    if (sys_reset === 1'b1) rst_seen <= 1'b1;
  end
  task automatic pulse(input int k);
    @(posedge mclk);
    pls[k] <= 1'b1;
    @(posedge mclk);
    pls[k] <= 1'b0;
  endtask : pulse
  task automatic save(input logic op);
    pwrsave_op <= op;
    pulse(P_SAVE);
    repeat (3) @(posedge mclk);
  endtask : save
  task automatic wait_cpu(output int lat);
    lat = 0;
    do begin
      @(negedge mclk);
      lat++;
    end while (cpu_clk_en !== 1'b1 && lat < 70000);
  endtask : wait_cpu
  task automatic flags_clear;
    reset_control_status_reg_wdata <= 16'h0000;
    pulse(P_WR);
    repeat (2) @(posedge mclk);
  endtask : flags_clear
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_config;
    logic [23:0] a[5] = '{PSW_ADDR_OSC_SEL, PSW_ADDR_OSC_CFG, PSW_ADDR_WDT_CFG, PSW_ADDR_POR_CFG, 24'hf80002};
    logic [15:0] v[5] = '{cfg_osc_sel, cfg_osc, cfg_wdt, cfg_por, 16'h0000};
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      tbl_rd   <= 1'b1;
      tbl_addr <= a[i];
      @(posedge mclk);
      tbl_rd <= 1'b0;
      @(negedge mclk);
      check(tbl_rdata === {8'h00, v[i]}, "config word read");
    end
  endtask : t_config
  task automatic t_sleep;
    logic [2:0] c[5] = '{PSW_OSC_FRC, PSW_OSC_EC, PSW_OSC_LP, PSW_OSC_PRI, PSW_OSC_PLL};
    int lo[5] = '{400, 400, 400, 416, 424};
    int lat;
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      cur_osc_sel <= c[i];
      save(PSW_OP_SLEEP);
      check(cpu_clk_en === 1'b0 && periph_clk_en === 8'h00, "sleep clocks");
      check(osc_en === (c[i] == PSW_OSC_LP), "sleep oscillator");
      pulse(P_IRQ);
      wait_cpu(lat);
      check(lat >= lo[i] && lat <= lo[i] + 12, "sleep wake latency");
      check(osc_restart_sel === c[i], "restart source");
      check(reset_control_status_reg_rdata[PSW_RESET_CONTROL_STATUS_REG_SLEEP] === 1'b1, "sleep flag");
      flags_clear();
    end
  endtask : t_sleep
  task automatic t_dead;
    logic seen;
    int   lat;
    for (int f = 1; f >= 0; f--) begin
      fail_safe_clock_monitor_en     <= f[0];
      dead        <= 1'b1;
      cur_osc_sel <= PSW_OSC_PRI;
      save(PSW_OP_SLEEP);
      pulse(P_IRQ);
      seen = 1'b0;
      repeat (700) @(negedge mclk) if (clk_fail_trap === 1'b1) seen = 1'b1;
      check(seen === f[0] && cpu_clk_en === f[0], "dead crystal outcome");
      if (f == 1) check(osc_restart_sel === PSW_OSC_FRC, "trap source");
      @(posedge mclk);
      dead <= 1'b0;
      wait_cpu(lat);
      check(lat < 200, "resume once clock runs");
      flags_clear();
    end
    fail_safe_clock_monitor_en <= 1'b0;
  endtask : t_dead
  task automatic t_idle;
    int lat;
    cur_osc_sel <= PSW_OSC_FRC;
    save(PSW_OP_IDLE);
    check(osc_en === 1'b1 && cpu_clk_en === 1'b0 && periph_clk_en === 8'hf0, "idle clocks");
    pulse(P_IRQ);
    wait_cpu(lat);
    check(lat <= 3, "idle wake latency");
    check(reset_control_status_reg_rdata[PSW_RESET_CONTROL_STATUS_REG_IDLE] === 1'b1, "idle flag on interrupt");
    flags_clear();
    save(PSW_OP_IDLE);
    pulse(P_MASTER_CLEAR_PIN);
    wait_cpu(lat);
    repeat (2) @(posedge mclk);
    check(reset_control_status_reg_rdata[PSW_RESET_CONTROL_STATUS_REG_IDLE] === 1'b1, "idle flag on master clear");
    save(PSW_OP_SLEEP);
    pulse(P_MASTER_CLEAR_PIN);
    wait_cpu(lat);
    check(lat < 500 && reset_control_status_reg_rdata[PSW_RESET_CONTROL_STATUS_REG_SLEEP] === 1'b1, "sleep flag on master clear");
    pulse(P_POR);
    wait_cpu(lat);
    repeat (2) @(posedge mclk);
    check(reset_control_status_reg_rdata[4:2] === 3'h0, "power-on clears flags");
  endtask : t_idle
  task automatic t_wdt;
    int lat;
    cfg_wdt   <= 16'hffff;
    low_power_rc_osc_tick <= 1'b1;
    pulse(P_CLR);
    repeat (1000) @(posedge mclk);
    pulse(P_CLR);
    save(PSW_OP_SLEEP);
    wait_cpu(lat);
    check(lat + 5 >= 65900 && lat + 5 <= 65970, "watchdog wake time");
    check(reset_control_status_reg_rdata[PSW_RESET_CONTROL_STATUS_REG_SLEEP] === 1'b1 && reset_control_status_reg_rdata[PSW_RESET_CONTROL_STATUS_REG_WATCHDOG_TIMEOUT_FLAG] === 1'b1, "timeout flags");
    check(rst_seen === 1'b0, "reset raised by a sleep time-out");
    @(posedge mclk);
    low_power_rc_osc_tick <= 1'b0;
    cfg_wdt   <= 16'hff7f;
  endtask : t_wdt
  initial begin
    {rst_n, pls, tbl_rd, pwrsave_op} = '0;
    {rst_seen, low_power_rc_osc_tick, fail_safe_clock_monitor_en, dead, tbl_addr, reset_control_status_reg_wdata, cyc, mismatches, n_tests} = '0;
    clk_switch_en    = 1'b1;
    cur_osc_sel      = PSW_OSC_FRC;
    periph_idle_stop = 8'h0f;
    cfg_osc_sel      = 16'h0003;
    cfg_osc          = 16'h0007;
    cfg_wdt          = 16'hff7f;
    cfg_por          = 16'hffff;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_config();
    t_sleep();
    t_dead();
    t_idle();
    t_wdt();
    end_of_test();
  end
endmodule : tb
